// ### pkg/lph_defines.svh
// constants for the line printer host handshake block
`ifndef LPH_DEFINES_SVH
`define LPH_DEFINES_SVH
`define LPH_COLUMNS 132
`define LPH_CHAR_W 8
`define LPH_COL_W 8
`define LPH_STATUS_NS 1000
`define LPH_STATUS_CYC ((`LPH_STATUS_NS + 9) / 10)
`define LPH_STEP_CYC 4
`define LPH_CHAR_CR 8'h0D
`define LPH_CHAR_LF 8'h0A
`define LPH_CHAR_FF 8'h0C
`endif

// ### pkg/lph_pkg.sv
// types shared by the line printer host handshake block
package lph_pkg;
	// character word passing through the buffer
	typedef struct packed {
		logic [7:0] data;
		logic term;
	} lph_char_t;
	// print sequence steps
	typedef enum logic [2:0] {
		LPH_ACCEPT = 3'b000,
		LPH_IDLE = 3'b001,
		LPH_LOAD = 3'b010,
		LPH_EDIT = 3'b011,
		LPH_PRINT = 3'b100,
		LPH_FORMAT = 3'b101,
		LPH_MOVE = 3'b110
	} lph_state_t;
	// fault inputs and status report
	typedef struct packed {
		logic not_ready;
		logic paper_out;
		logic cover_open;
		logic motion_fault;
	} lph_fault_t;
endpackage : lph_pkg

// ### rtl/lph_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module lph_buf2 #(
	parameter int W = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// two slots, head at slot rd
	logic [W-1:0] slot [2];
	logic rd;
	logic wr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// honest full stalls the source
	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = slot[rd];

	// occupancy and pointers
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 2'h0;
			rd <= 1'b0;
			wr <= 1'b0;
		end else begin
			if (push) wr <= ~wr;
			if (pop) rd <= ~rd;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (push) slot[wr] <= in_data;
	end
endmodule : lph_buf2
`default_nettype wire

// ### rtl/lph_port.sv
// host character port with line memory and print sequence
//
// Functional notes
// R01 - on line, report it then raise demand
// R02 - host answers demand with character plus strobe
// R03 - strobe drops demand and captures character
// R04 - store character, then demand again
// R05 - terminator stops data, runs print steps
// R06 - periodic status check reports faults
// R07 - line memory holds 132 columns
// R08 - host holds data, strobes only on demand
`timescale 1ns/100ps
`default_nettype none
`include "lph_defines.svh"
module lph_port #(
	parameter int COLUMNS = `LPH_COLUMNS,
	parameter int STATUS_CYC = `LPH_STATUS_CYC,
	parameter int STEP_CYC = `LPH_STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// operator and mechanism condition
	input wire logic ready_in,
	input wire logic online_sw,
	input wire lph_pkg::lph_fault_t faults,
	// host side handshake
	input wire logic [7:0] host_data,
	input wire logic host_strobe,
	output logic demand,
	output logic online,
	// status report
	output lph_pkg::lph_fault_t status,
	output logic status_change,
	// print engine view
	output lph_pkg::lph_state_t step,
	output logic [7:0] line_len,
	input wire logic [7:0] rd_col,
	output logic [7:0] rd_char
);
	// line memory of one print line
	logic [7:0] line_mem [COLUMNS];
	logic [7:0] col;
	lph_pkg::lph_state_t state;
	lph_pkg::lph_state_t next_state;
	logic [7:0] step_cnt;
	logic strobe_q;
	logic strobe_rise;
	logic waiting;
	lph_pkg::lph_char_t in_word;
	lph_pkg::lph_char_t out_word;
	logic in_ready;
	logic out_valid;
	logic out_ready;
	logic [31:0] stat_cnt;
	logic fault_any;

	assign fault_any = |status;
	assign step = state;
	assign strobe_rise = host_strobe && !strobe_q;

	// classify incoming character
	always_comb begin
		in_word.data = host_data;
		in_word.term = (host_data == `LPH_CHAR_CR) || (host_data == `LPH_CHAR_LF)
			|| (host_data == `LPH_CHAR_FF);
	end

	// strobe edge detect
	always_ff @(posedge clk) begin
		if (rst) strobe_q <= 1'b0;
		else strobe_q <= host_strobe;
	end

	// R01 online report
	always_ff @(posedge clk) begin
		if (rst) online <= 1'b0;
		else online <= ready_in && online_sw && !fault_any;
	end

	// demand is held low from strobe until the word has been taken
	always_ff @(posedge clk) begin
		if (rst) begin
			demand <= 1'b0;
			waiting <= 1'b0;
		end else if (state != lph_pkg::LPH_ACCEPT || !online) begin
			demand <= 1'b0;
			waiting <= 1'b0;
		// R03 drop demand on strobe
		end else if (strobe_rise && demand) begin
			demand <= 1'b0;
			waiting <= 1'b1;
		end else if (waiting) begin
			// R04 demand again after store
			if (!out_valid && in_ready) waiting <= 1'b0;
		end else begin
			// R01 raise demand when on line; full buffer holds it low
			demand <= in_ready;
		end
	end

	// R08 strobes outside demand are ignored, so a character strobed without demand is lost
	lph_buf2 #(
		.W($bits(lph_pkg::lph_char_t))
	) u_buf (
		.clk(clk),
		.rst(rst),
		// R03 capture on strobe
		.in_valid(strobe_rise && demand),
		.in_ready(in_ready),
		.in_data(in_word),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_word)
	);

	// drain only while collecting a line
	assign out_ready = (state == lph_pkg::LPH_ACCEPT);

	// R04 store into line memory; R07 excess columns dropped
	always_ff @(posedge clk) begin
		if (out_valid && out_ready && !out_word.term && col < 8'(COLUMNS))
			line_mem[col] <= out_word.data;
	end

	// column pointer
	always_ff @(posedge clk) begin
		if (rst) col <= 8'h00;
		else if (state == lph_pkg::LPH_MOVE && step_cnt == 8'(STEP_CYC - 1)) col <= 8'h00;
		else if (out_valid && out_ready && !out_word.term && col < 8'(COLUMNS))
			col <= col + 8'h01;
	end

	// print engine read port
	always_ff @(posedge clk) begin
		if (rst) rd_char <= 8'h00;
		else if (rd_col < 8'(COLUMNS)) rd_char <= line_mem[rd_col];
		else rd_char <= 8'h00;
	end

	// captured line length
	always_ff @(posedge clk) begin
		if (rst) line_len <= 8'h00;
		else if (state == lph_pkg::LPH_IDLE) line_len <= col;
	end

	// step timer
	always_ff @(posedge clk) begin
		if (rst || state == lph_pkg::LPH_ACCEPT || step_cnt == 8'(STEP_CYC - 1))
			step_cnt <= 8'h00;
		else step_cnt <= step_cnt + 8'h01;
	end

	// R05 print sequence after terminator
	always_comb begin
		next_state = state;
		case (state)
			lph_pkg::LPH_ACCEPT: begin
				if (out_valid && out_word.term) next_state = lph_pkg::LPH_IDLE;
			end
			lph_pkg::LPH_IDLE: begin
				// wait here while a fault stands
				if (step_cnt == 8'(STEP_CYC - 1) && !fault_any) next_state = lph_pkg::LPH_LOAD;
			end
			lph_pkg::LPH_LOAD: begin
				if (step_cnt == 8'(STEP_CYC - 1)) next_state = lph_pkg::LPH_EDIT;
			end
			lph_pkg::LPH_EDIT: begin
				if (step_cnt == 8'(STEP_CYC - 1)) next_state = lph_pkg::LPH_PRINT;
			end
			lph_pkg::LPH_PRINT: begin
				if (step_cnt == 8'(STEP_CYC - 1)) next_state = lph_pkg::LPH_FORMAT;
			end
			lph_pkg::LPH_FORMAT: begin
				if (step_cnt == 8'(STEP_CYC - 1)) next_state = lph_pkg::LPH_MOVE;
			end
			lph_pkg::LPH_MOVE: begin
				if (step_cnt == 8'(STEP_CYC - 1)) next_state = lph_pkg::LPH_ACCEPT;
			end
			default: next_state = lph_pkg::LPH_ACCEPT;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) state <= lph_pkg::LPH_ACCEPT;
		else state <= next_state;
	end

	// R06 periodic status sample
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_cnt <= 32'h0000_0000;
			status <= '0;
			status_change <= 1'b0;
		end else if (stat_cnt == 32'(STATUS_CYC - 1)) begin
			stat_cnt <= 32'h0000_0000;
			status.not_ready <= !ready_in;
			status.paper_out <= faults.paper_out;
			status.cover_open <= faults.cover_open;
			status.motion_fault <= faults.motion_fault;
			status_change <= ({!ready_in, faults.paper_out, faults.cover_open,
				faults.motion_fault} != status);
		end else begin
			stat_cnt <= stat_cnt + 32'h0000_0001;
			status_change <= 1'b0;
		end
	end
endmodule : lph_port
`default_nettype wire

// ### tb/lph_port_sva.sv
// assertions on the host character port
`timescale 1ns/100ps
`default_nettype none
module lph_port_sva (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic host_strobe,
	input wire logic demand,
	input wire logic online,
	input wire lph_pkg::lph_fault_t status,
	input wire lph_pkg::lph_state_t step,
	input wire logic [7:0] line_len
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_on; $rose(demand) |-> online; endproperty
	a_on: assert property (p_on) else $error("demand off line");
	property p_take; $rose(host_strobe) && demand |=> !demand; endproperty
	a_take: assert property (p_take) else $error("demand kept");
	property p_again; $fell(demand) && online |-> ##[1:6] (demand || step != 0 || !online);
	endproperty
	a_again: assert property (p_again) else $error("no new demand");
	property p_seq; step != 0 |-> !demand; endproperty
	a_seq: assert property (p_seq) else $error("demand in print");
	property p_hold; $changed(step) && step != 0 |=> $stable(step) [*3]; endproperty
	a_hold: assert property (p_hold) else $error("step short");
	property p_flt; status != 4'h0 && $past(status) != 4'h0 |-> !online; endproperty
	a_flt: assert property (p_flt) else $error("online in fault");
	property p_len; line_len <= 8'h84; endproperty
	a_len: assert property (p_len) else $error("line too long");
endmodule : lph_port_sva
bind lph_port lph_port_sva u_lph_port_sva (.clk(clk), .rst(rst), .host_strobe(host_strobe),
	.demand(demand), .online(online), .status(status), .step(step), .line_len(line_len));
`default_nettype wire

// ### tb/lph_host_model.sv
// host model answering demand with a character and a strobe
`timescale 1ns/100ps
`default_nettype none
module lph_host_model (
	// bench side
	input wire logic clk,
	input wire logic req,
	input wire logic [7:0] ch,
	input wire logic [3:0] lag,
	// port side
	input wire logic demand,
	output logic [7:0] host_data,
	output logic host_strobe,
	output logic busy
);
	logic sent = 1'b0; // strobed, waiting for demand drop
	logic [3:0] wait_n = 4'h0; // slow host delay
	initial begin
		host_data = 8'h5A;
		host_strobe = 1'b0;
		busy = 1'b0;
	end
	// falling edge keeps clear of the port's sampling edge
	always @(negedge clk) begin
		if (host_strobe) begin
			host_strobe <= 1'b0;
			// released lines show the inverse, never the last value
			host_data <= ~host_data;
		end else if (sent) begin
			if (!demand) begin
				sent <= 1'b0;
				busy <= 1'b0;
			end
		end else if (busy && demand) begin
			if (wait_n != 4'h0) wait_n <= wait_n - 4'h1;
			else begin
				host_strobe <= 1'b1;
				sent <= 1'b1;
			end
		end else if (req && !busy) begin
			busy <= 1'b1;
			wait_n <= lag;
			// data settles a cycle ahead of the strobe
			host_data <= ch;
		end
	end
endmodule : lph_host_model
`default_nettype wire

// ### tb/lph_port_bench.sv
// self-checking bench for the host character port
`timescale 1ns/100ps
`default_nettype none
module lph_port_bench;
	logic clk = 0, rst = 1, ready_in = 1, online_sw = 0, req = 0;
	logic host_strobe, demand, online, status_change, busy;
	logic [7:0] ch = 8'h00, rd_col = 8'h00, host_data, line_len, rd_char;
	logic [3:0] lag = 4'h0;
	lph_pkg::lph_fault_t faults = '0, status;
	lph_pkg::lph_state_t step;
	logic [7:0] mem [132]; // expected line memory
	int err_total = 0, n_checks = 0;
	always #5 clk = ~clk;
	lph_port #(.STATUS_CYC(20)) u_lph_port (.clk(clk), .rst(rst), .ready_in(ready_in),
		.online_sw(online_sw), .faults(faults), .host_data(host_data),
		.host_strobe(host_strobe), .demand(demand), .online(online), .status(status),
		.status_change(status_change), .step(step), .line_len(line_len), .rd_col(rd_col),
		.rd_char(rd_char));
	lph_host_model u_lph_host_model (.clk(clk), .req(req), .ch(ch), .lag(lag),
		.demand(demand), .host_data(host_data), .host_strobe(host_strobe), .busy(busy));
	task automatic cmp(string what, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	// expected count of stored columns
	function automatic int exp_len(int len);
		return len > 132 ? 132 : len;
	endfunction : exp_len
	// expected status word for one fault case
	function automatic logic [7:0] exp_status(int b);
		return 8'(1 << b);
	endfunction : exp_status
	// one character through the host model, random slowness
	task automatic put(logic [7:0] c);
		@(negedge clk);
		ch <= c;
		lag <= 4'($urandom_range(3));
		req <= 1'b1;
		@(negedge clk);
		req <= 1'b0;
		@(negedge clk);
		for (int i = 0; i < 80 && busy; i++) @(negedge clk);
	endtask : put
	task automatic send_line(int len, logic [7:0] term);
		int n;
		n = exp_len(len);
		for (int i = 0; i < len; i++) begin
			if (i < 132) mem[i] = 8'($urandom_range(8'h7E, 8'h20));
			put(i < 132 ? mem[i] : 8'h41);
		end
		put(term);
		for (int i = 0; i < 60 && step != lph_pkg::LPH_IDLE; i++) @(negedge clk);
		for (int s = 1; s < 7; s++) begin
			cmp("step", 8'(s), 8'(step));
			repeat (4) @(negedge clk);
		end
		cmp("step", 8'h00, 8'(step));
		cmp("line_len", 8'(n), line_len);
		for (int i = 0; i <= 132; i++) begin
			rd_col <= 8'(i);
			@(negedge clk);
			if (i < n || i == 132) cmp("rd_char", i < n ? mem[i] : 8'h00, rd_char);
		end
		$display("line %0d done", len);
	endtask : send_line
	task automatic wait_change();
		for (int i = 0; i < 60 && status_change !== 1'b1; i++) @(negedge clk);
		cmp("status_change", 8'h01, 8'(status_change));
		repeat (3) @(negedge clk);
	endtask : wait_change
	task automatic fault_case(int b);
		if (b < 3) faults <= lph_pkg::lph_fault_t'(4'(1 << b));
		else ready_in <= 1'b0;
		wait_change();
		cmp("status", exp_status(b), 8'(status));
		cmp("online", 8'h00, 8'(online));
		faults <= '0;
		ready_in <= 1'b1;
		wait_change();
		cmp("demand", 8'h01, 8'(demand));
		$display("fault %0d done", b);
	endtask : fault_case
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	initial begin
		void'($urandom(32'hFE6C));
		repeat (2) @(negedge clk);
		rst <= 1'b0;
		repeat (5) @(negedge clk);
		cmp("online", 8'h00, 8'(online));
		cmp("demand", 8'h00, 8'(demand));
		cmp("step", 8'h00, 8'(step));
		cmp("line_len", 8'h00, line_len);
		online_sw <= 1'b1;
		repeat (3) @(negedge clk);
		cmp("demand", 8'h01, 8'(demand));
		send_line(1 + $urandom_range(20), 8'h0D);
		send_line(140, 8'h0A);
		send_line(132, 8'h0C);
		for (int b = 0; b < 4; b++) fault_case(b);
		report_and_stop();
	end
	// tests need about 3000 cycles; a hang is cut far beyond that
	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end
endmodule : lph_port_bench
`default_nettype wire
